// ===== csi_cfg.svh
// configuration constants for the charger safety interlock supervisor
`ifndef CSI_CFG_SVH
`define CSI_CFG_SVH
// system clock and time base
`define CSI_CLK_HZ 100000000
`define CSI_CYC_PER_MS (`CSI_CLK_HZ / 1000)
// earth fault filter and shutdown deadlines, in milliseconds
`define CSI_T_FILT_MS 300
`define CSI_T_PILOT_MS 30
`define CSI_T_LATCH_MS 2000
`define CSI_T_OVP_MS 3000
`define CSI_T_EARTH_MS 5000
// analogue thresholds, whole amps and whole volts
`define CSI_I_SAFE_A 16'h0005
`define CSI_V_DISCH_V 16'h003C
`define CSI_V_UNLOCK_V 16'h000A
// register map, byte addresses
`define CSI_AW 8
`define CSI_OFS_STATUS 8'h00
`define CSI_OFS_CLEAR 8'h04
`define CSI_OFS_ENABLE 8'h08
`define CSI_OFS_CTRL 8'h0C
`define CSI_OFS_STATE 8'h10
// event bit positions in status, clear and enable
`define CSI_EV_W 5
`define CSI_EV_EARTH 0
`define CSI_EV_LATCH 1
`define CSI_EV_PILOT 2
`define CSI_EV_OVP 3
`define CSI_EV_LATE 4
// control register: pilot loss sense selection, one bit per pilot line
`define CSI_CTRL_W 3
`define CSI_CTRL_RST 3'h7
// reset values and bus answers
`define CSI_EV_RST 5'h00
`define CSI_RESP_OKAY 2'h0
`define CSI_RESP_SLVERR 2'h2
`endif

// ===== csi_pkg.sv
// types shared by the charger safety interlock supervisor
package csi_pkg;
  // shutdown sequence states, one-hot
  typedef enum logic [4:0] {
    csi_st_run = 5'h01,
    csi_st_cut = 5'h02,
    csi_st_open = 5'h04,
    csi_st_disch = 5'h08,
    csi_st_safe = 5'h10
  } csi_state_t;
  // cause of the running shutdown
  typedef enum logic [1:0] {
    csi_cz_earth = 2'h0,
    csi_cz_latch = 2'h1,
    csi_cz_pilot = 2'h2,
    csi_cz_ovp = 2'h3
  } csi_cause_t;
endpackage

// ===== csi_tmr_if.sv
// control bundle between the supervisor and one down-counting timer
`timescale 1ns/100ps
`default_nettype none
interface csi_tmr_if;
  logic load; // reload the counter this cycle
  logic [31:0] count; // reload value, cycles minus one
  logic run; // count down while high
  logic expired; // running and reached zero
  modport ctl (output load, output count, output run, input expired);
  modport tmr (input load, input count, input run, output expired);
endinterface
`default_nettype wire

// ===== csi_timer.sv
// down-counting timer used for the earth filter and the shutdown deadline
`timescale 1ns/100ps
`default_nettype none
module csi_timer (
  input wire logic clk_sys,
  input wire logic rst_b,
  csi_tmr_if.tmr tif
);
  logic [31:0] cnt_q; // remaining cycles
  logic [31:0] cnt_d;

  ////////////////////////////////////////////////////////////////////////////
  // next count: reload wins, then count down, saturate at zero
  always_comb begin
    cnt_d = cnt_q;
    if (tif.load) begin
      cnt_d = tif.count;
    end else if (tif.run && (cnt_q != 32'h0)) begin
      cnt_d = cnt_q - 32'h1;
    end
  end

  // reset to the top so nothing expires before the first reload
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_q <= 32'hFFFFFFFF;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // only meaningful while the owner keeps run high
  assign tif.expired = tif.run && !tif.load && (cnt_q == 32'h0);
endmodule // csi_timer
`default_nettype wire

// ===== csi_supervisor.sv
// safety interlock supervisor for a dc charging station, axi4-lite registers
// Functional notes
// - watch leakage current continuously, treat as earth fault
// - earth fault: first cut output current below 5 A
// - then open first start/stop switch
// - finally discharge output below 60 V
// - whole earth sequence within 5 s
// - earth detection faster than 1 s
// - earth detector slower than 0.2 s, continuous
// - earth fault latches permanent restart lockout
// - permit unlock only at 10 V or less
// - latch/lock failure keeps power lines de-energized
// - latch failure charging: cut within 2 s, then open
// - never open switches above 5 A
// - pilot loss charging: cut within 30 ms
// - overvoltage versus vehicle limit: cut within 3 s
// - closed switch asserts start signal to vehicle
`timescale 1ns/100ps
`default_nettype none
`include "csi_cfg.svh"
module csi_supervisor import csi_pkg::*; #(
  parameter int unsigned P_FILT_CYC = `CSI_T_FILT_MS * `CSI_CYC_PER_MS,
  parameter int unsigned P_PILOT_CYC = `CSI_T_PILOT_MS * `CSI_CYC_PER_MS,
  parameter int unsigned P_LATCH_CYC = `CSI_T_LATCH_MS * `CSI_CYC_PER_MS,
  parameter int unsigned P_OVP_CYC = `CSI_T_OVP_MS * `CSI_CYC_PER_MS,
  parameter int unsigned P_EARTH_CYC = `CSI_T_EARTH_MS * `CSI_CYC_PER_MS
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [`CSI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`CSI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic leakage_current_measure,
  input wire logic latch_fail,
  input wire logic station_pilot_one_ok,
  input wire logic station_pilot_two_ok,
  input wire logic vehicle_ready_pilot_ok,
  input wire logic charging_active,
  input wire logic [15:0] iout_meas,
  input wire logic [15:0] vout_meas,
  input wire logic [15:0] vehicle_vmax,
  input wire logic first_switch_req,
  input wire logic second_switch_req,
  input wire logic energize_req,
  input wire logic unlock_req,
  output logic current_cut,
  output logic voltage_discharge,
  output logic first_start_stop_switch,
  output logic second_start_stop_switch,
  output logic power_enable,
  output logic unlock_permit,
  output logic restart_lockout,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // timers: earth filter and shutdown deadline
  csi_tmr_if filt_if ();
  csi_tmr_if dl_if ();
  csi_timer u_filt (.clk_sys(clk_sys), .rst_b(rst_b), .tif(filt_if.tmr));
  csi_timer u_dl (.clk_sys(clk_sys), .rst_b(rst_b), .tif(dl_if.tmr));

  // supervisor state
  csi_state_t st_q, st_d;
  csi_cause_t cz_q, cz_d;
  logic prime_q, prime_d; // first cycle after reset primes the filter
  logic earth_det_q, earth_det_d; // filtered earth fault level
  logic lock_q, lock_d; // no-restart latch
  logic cut_q, cut_d;
  logic disch_q, disch_d;
  logic sw1_q, sw1_d;
  logic sw2_q, sw2_d;
  logic pwr_q, pwr_d;
  logic unl_q, unl_d;
  logic [`CSI_EV_W-1:0] stat_q, stat_d; // sticky causes
  logic irq_q, irq_d;
  // register bus state
  logic [`CSI_EV_W-1:0] en_q, en_d;
  logic [`CSI_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic awr_q, awr_d, wr_q, wr_d, aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [`CSI_AW-1:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0] ws_q, ws_d;
  logic bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic [31:0] rd_q, rd_d;
  logic [`CSI_EV_W-1:0] clr; // write-one-to-clear strobe from the bus

  // combinational helpers
  logic cur_lt_5, cur_le_5, pilot_loss, ovp, earth_new, late, in_seq;
  logic [`CSI_EV_W-1:0] ev;
  logic [`CSI_CTRL_W-1:0] pilot_dn;

  assign cur_lt_5 = iout_meas < `CSI_I_SAFE_A;
  assign cur_le_5 = iout_meas <= `CSI_I_SAFE_A;
  // software chooses which pilot lines count for loss detection
  assign pilot_dn = ctrl_q & ~{vehicle_ready_pilot_ok, station_pilot_two_ok, station_pilot_one_ok};
  assign pilot_loss = charging_active && (pilot_dn != 3'h0);
  assign ovp = charging_active && (vout_meas > vehicle_vmax);

  ////////////////////////////////////////////////////////////////////////////
  // earth filter: reload whenever leakage drops, so the threshold must hold
  // for the whole interval; any dip restarts it and avoids nuisance trips
  assign filt_if.load = prime_q || !leakage_current_measure;
  assign filt_if.run = leakage_current_measure;
  assign filt_if.count = 32'(P_FILT_CYC - 1);
  assign earth_new = filt_if.expired && !earth_det_q;

  // deadline covers current reduction, or the whole sequence for earth
  assign in_seq = (st_q == csi_st_cut) ||
                  ((cz_q == csi_cz_earth) && ((st_q == csi_st_open) || (st_q == csi_st_disch)));
  assign dl_if.run = in_seq;
  assign late = dl_if.expired;

  ////////////////////////////////////////////////////////////////////////////
  // shutdown sequencing, switch gating and status
  always_comb begin
    st_d = st_q;
    cz_d = cz_q;
    dl_if.load = 1'b0;
    dl_if.count = 32'(P_EARTH_CYC - 1);
    prime_d = 1'b0;
    earth_det_d = filt_if.expired;
    lock_d = lock_q || earth_new; // only reset releases it
    case (st_q)
      csi_st_run: begin
        // priority earth, latch, pilot, overvoltage
        if (earth_new) begin
          st_d = csi_st_cut;
          cz_d = csi_cz_earth;
        end else if (latch_fail && charging_active) begin
          st_d = csi_st_cut;
          cz_d = csi_cz_latch;
        end else if (pilot_loss) begin
          st_d = csi_st_cut;
          cz_d = csi_cz_pilot;
        end else if (ovp) begin
          st_d = csi_st_cut;
          cz_d = csi_cz_ovp;
        end
      end
      csi_st_cut: begin
        // wait for the power stage to bring current below 5 A
        if (cur_lt_5) begin
          st_d = csi_st_open;
        end
      end
      csi_st_open: begin
        // switches fall as soon as current allows
        if (!sw1_q && !sw2_q) begin
          st_d = (cz_q == csi_cz_earth) ? csi_st_disch : csi_st_safe;
        end
      end
      csi_st_disch: begin
        if (vout_meas < `CSI_V_DISCH_V) begin
          st_d = csi_st_safe;
        end
      end
      csi_st_safe: begin
        // leave only when quiet, off-charge and not locked out
        if (!lock_q && !charging_active && !latch_fail && !earth_det_q) begin
          st_d = csi_st_run;
        end
      end
      default: begin
        st_d = csi_st_safe;
      end
    endcase
    // a fresh earth fault restarts the sequence from any later state
    if (earth_new && (st_q != csi_st_run)) begin
      st_d = csi_st_cut;
      cz_d = csi_cz_earth;
    end
    if ((st_d == csi_st_cut) && ((st_q == csi_st_run) || earth_new)) begin
      dl_if.load = 1'b1;
      case (cz_d)
        csi_cz_earth: dl_if.count = 32'(P_EARTH_CYC - 1);
        csi_cz_latch: dl_if.count = 32'(P_LATCH_CYC - 1);
        csi_cz_pilot: dl_if.count = 32'(P_PILOT_CYC - 1);
        default: dl_if.count = 32'(P_OVP_CYC - 1);
      endcase
    end
    // current command held from the first faulted edge onward
    cut_d = (st_d != csi_st_run) || lock_d;
    disch_d = (st_d == csi_st_disch) || (lock_d && (st_d == csi_st_safe));
    // closed switch asserts start; opening waits for safe current
    if (sw1_q) begin
      sw1_d = !(((st_d != csi_st_run) || lock_d || !first_switch_req) && cur_le_5);
    end else begin
      sw1_d = first_switch_req && (st_d == csi_st_run) && !lock_d;
    end
    if (sw2_q) begin
      sw2_d = !(((st_d != csi_st_run) || lock_d || !second_switch_req) && cur_le_5);
    end else begin
      sw2_d = second_switch_req && (st_d == csi_st_run) && !lock_d;
    end
    pwr_d = energize_req && (st_d == csi_st_run) && !lock_d && !latch_fail;
    unl_d = unlock_req && (vout_meas <= `CSI_V_UNLOCK_V);
    // sticky causes: a new event wins over a clear in the same cycle
    ev = '0;
    ev[`CSI_EV_EARTH] = earth_new;
    ev[`CSI_EV_LATCH] = latch_fail;
    ev[`CSI_EV_PILOT] = pilot_loss;
    ev[`CSI_EV_OVP] = ovp;
    ev[`CSI_EV_LATE] = late;
    stat_d = (stat_q & ~clr) | ev;
    irq_d = (stat_d & en_q) != `CSI_EV_RST;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_q <= csi_st_run;
      cz_q <= csi_cz_earth;
      prime_q <= 1'b1;
      earth_det_q <= 1'b0;
      lock_q <= 1'b0;
      cut_q <= 1'b0;
      disch_q <= 1'b0;
      sw1_q <= 1'b0;
      sw2_q <= 1'b0;
      pwr_q <= 1'b0;
      unl_q <= 1'b0;
      stat_q <= `CSI_EV_RST;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cz_q <= cz_d;
      prime_q <= prime_d;
      earth_det_q <= earth_det_d;
      lock_q <= lock_d;
      cut_q <= cut_d;
      disch_q <= disch_d;
      sw1_q <= sw1_d;
      sw2_q <= sw2_d;
      pwr_q <= pwr_d;
      unl_q <= unl_d;
      stat_q <= stat_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: one write and one read in flight, either aw/w order
  logic aw_have, w_have, do_wr, do_rd;
  logic [`CSI_AW-1:0] wa;
  logic [31:0] wdv;
  logic [3:0] wsv;

  always_comb begin
    aw_have = aw_got_q || (awvalid && awr_q);
    w_have = w_got_q || (wvalid && wr_q);
    wa = aw_got_q ? awa_q : awaddr;
    wdv = w_got_q ? wd_q : wdata;
    wsv = w_got_q ? ws_q : wstrb;
    do_wr = aw_have && w_have && !bv_q;
    do_rd = arvalid && arr_q;
    awa_d = (awvalid && awr_q) ? awaddr : awa_q;
    wd_d = (wvalid && wr_q) ? wdata : wd_q;
    ws_d = (wvalid && wr_q) ? wstrb : ws_q;
    aw_got_d = aw_have && !do_wr;
    w_got_d = w_have && !do_wr;
    bv_d = do_wr || (bv_q && !bready);
    br_d = br_q;
    en_d = en_q;
    ctrl_d = ctrl_q;
    clr = '0;
    if (do_wr) begin
      br_d = `CSI_RESP_OKAY;
      case (wa)
        `CSI_OFS_STATUS, `CSI_OFS_STATE: begin
          // read-only words ignore writes
        end
        `CSI_OFS_CLEAR: begin
          if (wsv[0]) clr = wdv[`CSI_EV_W-1:0];
        end
        `CSI_OFS_ENABLE: begin
          if (wsv[0]) en_d = wdv[`CSI_EV_W-1:0];
        end
        `CSI_OFS_CTRL: begin
          if (wsv[0]) ctrl_d = wdv[`CSI_CTRL_W-1:0];
        end
        default: begin
          br_d = `CSI_RESP_SLVERR;
        end
      endcase
    end
    // ready drops while a word is held or the response is pending
    awr_d = !aw_got_d && !bv_d;
    wr_d = !w_got_d && !bv_d;
    rv_d = do_rd || (rv_q && !rready);
    arr_d = !rv_d;
    rd_d = rd_q;
    rr_d = rr_q;
    if (do_rd) begin
      rr_d = `CSI_RESP_OKAY;
      case (araddr)
        `CSI_OFS_STATUS: rd_d = {27'h0000000, stat_q};
        `CSI_OFS_CLEAR: rd_d = 32'h00000000;
        `CSI_OFS_ENABLE: rd_d = {27'h0000000, en_q};
        `CSI_OFS_CTRL: rd_d = {29'h00000000, ctrl_q};
        `CSI_OFS_STATE: rd_d = {20'h00000, disch_q, cut_q, lock_q, cz_q, sw2_q, sw1_q, st_q};
        default: begin
          rd_d = 32'h00000000;
          rr_d = `CSI_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      en_q <= `CSI_EV_RST;
      ctrl_q <= `CSI_CTRL_RST;
      awr_q <= 1'b0;
      wr_q <= 1'b0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awa_q <= '0;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
      bv_q <= 1'b0;
      br_q <= `CSI_RESP_OKAY;
      arr_q <= 1'b0;
      rv_q <= 1'b0;
      rr_q <= `CSI_RESP_OKAY;
      rd_q <= 32'h00000000;
    end else begin
      en_q <= en_d;
      ctrl_q <= ctrl_d;
      awr_q <= awr_d;
      wr_q <= wr_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bv_q <= bv_d;
      br_q <= br_d;
      arr_q <= arr_d;
      rv_q <= rv_d;
      rr_q <= rr_d;
      rd_q <= rd_d;
    end
  end

  // every output straight from a flip-flop
  assign awready = awr_q;
  assign wready = wr_q;
  assign bvalid = bv_q;
  assign bresp = br_q;
  assign arready = arr_q;
  assign rvalid = rv_q;
  assign rresp = rr_q;
  assign rdata = rd_q;
  assign current_cut = cut_q;
  assign voltage_discharge = disch_q;
  assign first_start_stop_switch = sw1_q;
  assign second_start_stop_switch = sw2_q;
  assign power_enable = pwr_q;
  assign unlock_permit = unl_q;
  assign restart_lockout = lock_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sw1_open_safe_a: assert property (
    $fell(first_start_stop_switch) |-> $past(iout_meas) <= `CSI_I_SAFE_A)
    else $error("switch one opened above safe current");
  sw2_open_safe_a: assert property (
    $fell(second_start_stop_switch) |-> $past(iout_meas) <= `CSI_I_SAFE_A)
    else $error("switch two opened above safe current");
  earth_cut_a: assert property (
    earth_new |=> current_cut && restart_lockout)
    else $error("earth fault did not cut current");
  earth_filter_a: assert property (
    earth_new |-> $past(leakage_current_measure, 1) && $past(leakage_current_measure, 2))
    else $error("earth fault declared without sustained leakage");
  lockout_hold_a: assert property (
    restart_lockout |=> restart_lockout && !power_enable && !$rose(first_start_stop_switch))
    else $error("lockout released or power re-enabled");
  unlock_volt_a: assert property (
    unlock_permit |-> $past(vout_meas) <= `CSI_V_UNLOCK_V)
    else $error("unlock permitted above safe voltage");
  latch_power_a: assert property (
    latch_fail |=> !power_enable)
    else $error("power enabled during latch failure");
  open_after_cut_a: assert property (
    (st_q == csi_st_open) && cur_le_5 |=> !first_start_stop_switch)
    else $error("switch one not opened after current cut");
  pilot_cut_a: assert property (
    pilot_loss && (st_q == csi_st_run) |=> current_cut)
    else $error("pilot loss did not cut current");
  ovp_cut_a: assert property (
    ovp && (st_q == csi_st_run) |=> current_cut)
    else $error("overvoltage did not cut current");
  sticky_cause_a: assert property (
    ev[`CSI_EV_EARTH] |=> stat_q[`CSI_EV_EARTH] ##1 (stat_q[`CSI_EV_EARTH] || $past(clr[`CSI_EV_EARTH])))
    else $error("earth cause not held in status");
endmodule // csi_supervisor
`default_nettype wire

// ===== csi_conv_model.sv
// behavioural power stage model facing the supervisor outputs
`timescale 1ns/100ps
`default_nettype none
module csi_conv_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic current_cut,
  input wire logic voltage_discharge,
  input wire logic slow,
  input wire logic [15:0] i_set,
  input wire logic [15:0] v_set,
  output logic [15:0] iout_meas,
  output logic [15:0] vout_meas
);
  logic [15:0] step; // amps shed per cycle while cutting
  // slow shedding lets a deadline run out on purpose
  assign step = slow ? 16'h0001 : 16'h0008;
  ////////////////////////////////////////////////////////////
  // current and voltage follow set points unless commanded down
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      iout_meas <= 16'h0000;
      vout_meas <= 16'h0000;
    end else begin
      if (current_cut) begin
        iout_meas <= (iout_meas > step) ? iout_meas - step : 16'h0000;
      end else begin
        iout_meas <= i_set;
      end
      if (voltage_discharge) begin
        vout_meas <= (vout_meas > 16'h000A) ? vout_meas - 16'h000A : 16'h0000;
      end else begin
        vout_meas <= v_set;
      end
    end
  end
endmodule // csi_conv_model
`default_nettype wire

// ===== charger_safety_interlock_supervisor_tb_top.sv
// self-checking bench for the safety interlock supervisor
`timescale 1ns/100ps
`default_nettype none
`include "csi_cfg.svh"
module charger_safety_interlock_supervisor_tb_top;
  localparam int FILT = 20; // shortened earth filter
  logic clk_sys, rst_b;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic leak, latch_fail, p1, p2, p3, chg, sreq, ereq, ureq, slow;
  logic [15:0] iout_meas, vout_meas, i_set, v_set, vmax;
  logic cut, dis, sw1, sw2, pwr, ulp, lock, irq;
  int fail_count, total_checks;
  ////////////////////////////////////////////////////////////
  csi_supervisor #(.P_FILT_CYC(FILT), .P_PILOT_CYC(10), .P_LATCH_CYC(40), .P_OVP_CYC(60),
    .P_EARTH_CYC(100)) csi_supervisor_i (
    .clk_sys, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .leakage_current_measure(leak), .latch_fail, .station_pilot_one_ok(p1),
    .station_pilot_two_ok(p2), .vehicle_ready_pilot_ok(p3), .charging_active(chg),
    .iout_meas, .vout_meas, .vehicle_vmax(vmax), .first_switch_req(sreq),
    .second_switch_req(sreq), .energize_req(ereq), .unlock_req(ureq), .current_cut(cut),
    .voltage_discharge(dis), .first_start_stop_switch(sw1), .second_start_stop_switch(sw2),
    .power_enable(pwr), .unlock_permit(ulp), .restart_lockout(lock), .irq);
  csi_conv_model csi_conv_model_i (.clk_sys, .rst_b, .current_cut(cut),
    .voltage_discharge(dis), .slow, .i_set, .v_set, .iout_meas, .vout_meas);
  ////////////////////////////////////////////////////////////
  // free-running 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  // axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(negedge clk_sys);
    while (awvalid || wvalid) begin
      ta = awready === 1'b1;
      tw = wready === 1'b1;
      @(posedge clk_sys);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      @(negedge clk_sys);
    end
    while (bvalid !== 1'b1) @(negedge clk_sys);
    chk(bresp, `CSI_RESP_OKAY);
    @(posedge clk_sys);
    bready <= 1'b0;
  endtask
  // axi4-lite read, answer taken at the first falling clock edge that sees rvalid high
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(negedge clk_sys);
    while (arready !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
    arvalid <= 1'b0;
    @(negedge clk_sys);
    while (rvalid !== 1'b1) @(negedge clk_sys);
    d = rdata;
    r = rresp;
    @(posedge clk_sys);
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk(r, `CSI_RESP_OKAY);
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    cyc(2);
  endtask
  // drop every fault except leakage, let the sequence return to run, clear status
  task automatic recover();
    @(posedge clk_sys);
    chg <= 1'b0;
    latch_fail <= 1'b0;
    {p1, p2, p3} <= 3'h7;
    v_set <= 16'd300;
    slow <= 1'b0;
    do @(negedge clk_sys); while (cut !== 1'b0);
    wr(`CSI_OFS_CLEAR, 32'h1F);
    rdc(`CSI_OFS_STATUS, 32'h0);
    cyc(1);
    chk(irq, 1'b0);
    @(posedge clk_sys);
    chg <= 1'b1;
    cyc(4);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rdc(`CSI_OFS_STATUS, 32'h0);
    rdc(`CSI_OFS_ENABLE, 32'h0);
    rdc(`CSI_OFS_CTRL, 32'h7);
    rdc(`CSI_OFS_STATE, 32'h1);
    rd(8'h20, d, r);
    chk(r, `CSI_RESP_SLVERR);
    chk(d, 32'h0);
    wr(`CSI_OFS_STATUS, 32'h1F);
    rdc(`CSI_OFS_STATUS, 32'h0);
  endtask
  task automatic t_run();
    @(posedge clk_sys);
    chg <= 1'b1;
    sreq <= 1'b1;
    ereq <= 1'b1;
    cyc(4);
    chk({sw1, sw2, pwr}, 3'h7);
    rdc(`CSI_OFS_STATE, 32'h61);
  endtask
  task automatic t_unlock();
    @(posedge clk_sys);
    ureq <= 1'b1;
    v_set <= 16'd11;
    cyc(4);
    chk(ulp, 1'b0);
    @(posedge clk_sys);
    v_set <= 16'd10;
    cyc(4);
    chk(ulp, 1'b1);
    @(posedge clk_sys);
    ureq <= 1'b0;
    v_set <= 16'd300;
  endtask
  task automatic t_ovp();
    wr(`CSI_OFS_ENABLE, 32'h08);
    v_set <= 16'd400;
    cyc(6);
    chk(cut, 1'b0);
    @(posedge clk_sys);
    v_set <= 16'd401;
    cyc(4);
    chk(cut, 1'b1);
    chk(irq, 1'b1);
    rdc(`CSI_OFS_STATUS, 32'h08);
    wr(`CSI_OFS_ENABLE, 32'h0);
    cyc(2);
    chk(irq, 1'b0);
    recover();
  endtask
  task automatic t_pilot();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      slow <= (i == 0);
      {p3, p2, p1} <= ~(3'h1 << i);
      cyc(3);
      chk(cut, 1'b1);
      while (sw1 !== 1'b0) @(negedge clk_sys);
      chk(iout_meas > 16'h0005, 1'b0);
      rdc(`CSI_OFS_STATUS, (i == 0) ? 32'h14 : 32'h04);
      recover();
    end
    wr(`CSI_OFS_CTRL, 32'h6);
    p1 <= 1'b0;
    cyc(8);
    chk(cut, 1'b0);
    @(posedge clk_sys);
    p1 <= 1'b1;
    wr(`CSI_OFS_CTRL, 32'h7);
  endtask
  task automatic t_latch();
    @(posedge clk_sys);
    slow <= 1'b1;
    latch_fail <= 1'b1;
    cyc(3);
    chk({cut, pwr}, 2'h2);
    cyc(3);
    chk({sw1, sw2}, 2'h3);
    while (sw1 !== 1'b0) @(negedge clk_sys);
    chk(iout_meas > 16'h0005, 1'b0);
    chk(sw2, 1'b0);
    rdc(`CSI_OFS_STATUS, 32'h02);
    recover();
  endtask
  task automatic t_earth();
    int n;
    wr(`CSI_OFS_ENABLE, 32'h01);
    @(posedge clk_sys);
    leak <= 1'b1;
    repeat (FILT - 1) @(posedge clk_sys);
    leak <= 1'b0;
    cyc(6);
    chk(cut, 1'b0);
    @(posedge clk_sys);
    leak <= 1'b1;
    n = 0;
    while (cut !== 1'b1) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n >= FILT && n <= FILT + 3, 1'b1);
    chk({lock, irq}, 2'h3);
    while (dis !== 1'b1) @(negedge clk_sys);
    chk({sw1, sw2}, 2'h0);
    chk(iout_meas > 16'h0004, 1'b0);
    while (vout_meas >= 16'h003C) @(negedge clk_sys);
    cyc(3);
    rdc(`CSI_OFS_STATE, 32'hE10);
    rdc(`CSI_OFS_STATUS, 32'h01);
    leak <= 1'b0;
    chg <= 1'b0;
    cyc(20);
    chk({cut, pwr, sw1}, 3'h4);
    wr(`CSI_OFS_CLEAR, 32'h01);
    rdc(`CSI_OFS_STATUS, 32'h0);
    cyc(1);
    chk({irq, lock}, 2'h1);
    do_reset();
    chk(lock, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // watchdog: the whole run needs a few hundred cycles
  initial begin
    #200000;
    fail_count++;
    conclude();
  end
  // main sequence
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready} <= 6'h0;
    {awaddr, araddr, wdata, wstrb} <= 52'h0;
    {leak, latch_fail, chg, sreq, ereq, ureq, slow} <= 7'h0;
    {p1, p2, p3} <= 3'h7;
    i_set <= 16'd20;
    v_set <= 16'd300;
    vmax <= 16'd400;
    do_reset();
    t_regs();
    t_run();
    t_unlock();
    t_ovp();
    t_pilot();
    t_latch();
    t_earth();
    conclude();
  end
endmodule // charger_safety_interlock_supervisor_tb_top
`default_nettype wire
